// ---- fpu_regs.svh ----
`ifndef FPU_REGS_SVH
`define FPU_REGS_SVH

// Register byte offsets on the control bus.
`define OFF_CTRL 8'h00
`define OFF_OPSPEC 8'h04
`define OFF_GPR_IN 8'h08
`define OFF_STATUS 8'h0C
`define OFF_EXC 8'h10
`define OFF_ADDR 8'h14
`define OFF_STEP 8'h18
`define OFF_RES_HI 8'h1C
`define OFF_RES_LO 8'h20
`define OFF_A_HI 8'h24
`define OFF_A_LO 8'h28
`define OFF_B_HI 8'h2C
`define OFF_B_LO 8'h30

// Control register field positions.
`define CTRL_TRUNC 0
`define CTRL_DOUBLE 1
`define CTRL_IUV 2
`define CTRL_IV 3
`define CTRL_IU 4

// Exception codes.
`define EXC_NONE 4'h0
`define EXC_ILLOP 4'h2
`define EXC_DIVZ 4'h4
`define EXC_ICONV 4'h6
`define EXC_OVF 4'h8
`define EXC_UNF 4'hA
`define EXC_UNDEF 4'hC

// Address steps in bytes and word counts per operand.
`define STEP_SINGLE 16'h0004
`define STEP_DOUBLE 16'h0008
`define WORDS_SINGLE 3'h2
`define WORDS_DOUBLE 3'h4

// Exponent wrap, fraction widths and control reset value.
`define EXP_WRAP 10'h100
`define FRAC_S 24
`define FRAC_D 56
`define CTRL_RESET 5'h00

`endif

// ---- fpu_pkg.sv ----
package fpu_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CALC = 2'b01, ST_DONE = 2'b11} state_t;
  typedef enum logic [1:0] {OP_ADD = 2'h0, OP_SUB = 2'h1, OP_MUL = 2'h2, OP_DIV = 2'h3} op_t;
  typedef struct packed {
    logic sign;
    logic [7:0] bexp;
    logic [54:0] frac;
  } fp_t;
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] reg_sel;
    logic [2:0] ac_sel;
    op_t op;
  } opspec_t;
endpackage : fpu_pkg

// ---- fp_operand_address_and_rounding.sv ----
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fpu_regs.svh"

// Behaviour
// RULE1: mode 0 uses named float accumulator
// RULE2: modes 1-7 follow host addressing
// RULE3: step 4 single, 8 double bytes
// RULE4: mode 0 accumulators 6,7 trap illegal
// RULE5: memory modes limited to accumulators 0-3
// RULE6: lowest address holds most significant word
// RULE7: zero exponent is zero; negative zero traps; the code returns A for a nonzero A times a zero B, and traps on negative zero only when CTRL_IUV is set
// RULE8: zero divisor undefined and interrupts
// RULE9: fraction 24 or 56 bits normalized
// RULE10: two guard bits kept for rounding
// RULE11: round adds one LSB when bit set
// RULE12: exponent outside eight bits flags error
// RULE13: underflow without enable gives zero
// RULE14: enabled error stores fraction, low exponent
// RULE15: overflow stored exponent 400 octal smaller
// RULE16: underflow nonzero stored exponent 400 larger
// RULE17: fraction accuracy kept on range errors
// RULE18: truncate select chops, else rounds
// RULE19: double select picks double precision
// RULE20: four-bit exception code register
// RULE21: disabled overflow gives zero, no interrupt
// RULE22: two or four ascending memory words
module fp_operand_address_and_rounding (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic float_trap
);
  import fpu_pkg::*;

  // ==========================================================
  // Register state
  // ==========================================================
  logic [4:0] ctrl_reg, ctrl_next;
  opspec_t spec_reg, spec_next;
  logic [15:0] gpr_reg, gpr_next;
  logic [15:0] addr_reg, addr_next;
  logic [15:0] step_reg, step_next;
  logic [3:0] exception_code_reg, exc_next;
  logic overflow_flag, ovf_next;
  logic trap_reg, trap_next;
  logic [63:0] a_reg, a_next, b_reg, b_next, res_reg, res_next;
  logic [63:0] float_accumulators [0:5];
  state_t state_reg, state_next;
  logic start;
  logic aw_full, w_full, aw_full_next, w_full_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;

  logic truncate_select, double_precision_select;
  assign truncate_select = ctrl_reg[`CTRL_TRUNC];
  assign double_precision_select = ctrl_reg[`CTRL_DOUBLE];

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  // Address and data are latched separately so either may come first.
  assign s_axi_awready = !aw_full && !bvalid_reg;
  assign s_axi_wready = !w_full && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign float_trap = trap_reg;

  logic do_write;
  logic [7:0] wa;
  assign do_write = aw_full && w_full && !bvalid_reg;
  assign wa = awa_reg;

  always_comb
  begin
    aw_full_next = aw_full;
    w_full_next = w_full;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_next = 1'b1;
      awa_next = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (do_write)
    begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wa <= `OFF_GPR_IN || (wa >= `OFF_A_HI && wa <= `OFF_B_LO)) &&
        wa[1:0] == 2'b00 ? 2'b00 : 2'b10;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = 2'b00;
      unique case (s_axi_araddr[7:0])
        `OFF_CTRL: rdata_next = {27'h0, ctrl_reg};
        `OFF_OPSPEC: rdata_next = {21'h0, spec_reg};
        `OFF_GPR_IN: rdata_next = {16'h0, gpr_reg};
        `OFF_STATUS: rdata_next = {27'h0, overflow_flag, trap_reg, 1'b0, state_reg};
        `OFF_EXC: rdata_next = {28'h0, exception_code_reg};
        `OFF_ADDR: rdata_next = {16'h0, addr_reg};
        `OFF_STEP: rdata_next = {16'h0, step_reg};
        `OFF_RES_HI: rdata_next = res_reg[63:32];
        `OFF_RES_LO: rdata_next = res_reg[31:0];
        `OFF_A_HI: rdata_next = a_reg[63:32];
        `OFF_A_LO: rdata_next = a_reg[31:0];
        `OFF_B_HI: rdata_next = b_reg[63:32];
        `OFF_B_LO: rdata_next = b_reg[31:0];
        default:
        begin
          rdata_next = 32'h0;
          rresp_next = 2'b10;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'b00;
    end
    else
    begin
      aw_full <= aw_full_next;
      w_full <= w_full_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ==========================================================
  // Arithmetic core
  // ==========================================================
  // Operands are held left-aligned: hidden bit at bit 55 of a 56 bit fraction,
  // single precision uses only the upper 24 bits.
  logic [55:0] fa, fb, pre_mask;
  logic [57:0] fsum;
  logic [113:0] prod;
  logic [57:0] quo;
  logic [113:0] qfull;
  logic [59:0] norm;
  logic [9:0] exp_raw;
  logic rbit, res_sign, a_zero, b_zero, neg_zero, ovf, unf;
  logic [56:0] rounded;
  logic [55:0] frac_out;
  logic [9:0] exp_out;
  logic [3:0] calc_exc;
  logic calc_trap;
  logic [63:0] calc_res;
  integer k;

  assign a_zero = a_reg[62:55] == 8'h00; // [RULE7]
  assign b_zero = b_reg[62:55] == 8'h00; // [RULE7]
  assign fa = {1'b1, a_reg[54:0]}; // [RULE9]
  assign fb = {1'b1, b_reg[54:0]}; // [RULE9]
  assign pre_mask = double_precision_select ? {56{1'b1}} : {{24{1'b1}}, 32'h0}; // [RULE19]

  always_comb
  begin
    fsum = 58'h0;
    prod = fa * fb;
    quo = 58'h0;
    qfull = 114'h0;
    norm = 60'h0;
    exp_raw = 10'h0;
    res_sign = a_reg[63];
    unique case (spec_reg.op)
      OP_ADD, OP_SUB:
      begin
        // Alignment keeps two guard bits below the fraction width.
        if (a_reg[62:55] >= b_reg[62:55])
        begin
          fsum = {fa, 2'b00};
          norm = {2'b00, fb, 2'b00} >> (a_reg[62:55] - b_reg[62:55]); // [RULE10]
          exp_raw = {2'b00, a_reg[62:55]};
        end
        else
        begin
          fsum = {fb, 2'b00};
          norm = {2'b00, fa, 2'b00} >> (b_reg[62:55] - a_reg[62:55]); // [RULE10]
          exp_raw = {2'b00, b_reg[62:55]};
          res_sign = b_reg[63] ^ (spec_reg.op == OP_SUB);
        end
        if ((a_reg[63] ^ b_reg[63] ^ (spec_reg.op == OP_SUB)) == 1'b0)
          norm = {{1'b0, fsum} + {1'b0, norm[57:0]}, 1'b0};
        else if (fsum >= norm[57:0])
          norm = {1'b0, fsum - norm[57:0], 1'b0};
        else
        begin
          norm = {1'b0, norm[57:0] - fsum, 1'b0};
          res_sign = ~res_sign;
        end
        // Bit 59 holds the carry; cancellation may need many left shifts.
        exp_raw = exp_raw + 10'h1;
        for (int j = 0; j < 59; j++)
        begin
          if (!norm[59] && norm != 60'h0)
          begin
            norm = {norm[58:0], 1'b0};
            exp_raw = exp_raw - 10'h1;
          end
        end
      end
      OP_MUL:
      begin
        res_sign = a_reg[63] ^ b_reg[63];
        norm = {prod[111:54], prod[53:52] != 2'b00}; // [RULE10]
        norm = {norm[58:0], 1'b0};
        exp_raw = {2'b00, a_reg[62:55]} + {2'b00, b_reg[62:55]} - 10'h080;
        if (norm[59] == 1'b0)
        begin
          norm = {norm[58:0], 1'b0};
          exp_raw = exp_raw - 10'h1;
        end
      end
      default:
      begin
        res_sign = a_reg[63] ^ b_reg[63];
        // A quotient of one or more needs bit 58, so the lowest bit is dropped.
        qfull = {fa, 58'h0} / {58'h0, fb};
        quo = qfull[58:1]; // [RULE10]
        norm = {quo, 2'b00};
        exp_raw = {2'b00, a_reg[62:55]} - {2'b00, b_reg[62:55]} + 10'h081;
        if (norm[59] == 1'b0)
        begin
          norm = {norm[58:0], 1'b0};
          exp_raw = exp_raw - 10'h1;
        end
      end
    endcase
  end

  // Chop keeps the precision's fraction; round adds one LSB when the first dropped bit is set.
  always_comb
  begin
    rbit = double_precision_select ? norm[3] : norm[35]; // [RULE11]
    rounded = {1'b0, norm[59:4] & pre_mask};
    if (!truncate_select && rbit) // [RULE18]
      rounded = rounded + (double_precision_select ? 57'h1 : 57'h100000000); // [RULE11]
    frac_out = rounded[56] ? rounded[56:1] : rounded[55:0];
    exp_out = exp_raw + {9'h0, rounded[56]};
    for (k = 0; k < 1; k = k + 1)
      frac_out = frac_out & pre_mask;
  end

  assign neg_zero = (a_zero && a_reg[63]) || (b_zero && b_reg[63] && spec_reg.op != OP_DIV);
  assign ovf = !exp_out[9] && (exp_out[8]); // [RULE12]
  assign unf = exp_out[9] || exp_out == 10'h000; // [RULE12]

  always_comb
  begin
    calc_exc = `EXC_NONE;
    calc_trap = 1'b0;
    calc_res = {res_sign, exp_out[7:0], frac_out[54:0]}; // [RULE14] [RULE17]
    if (neg_zero && ctrl_reg[`CTRL_IUV])
    begin
      calc_exc = `EXC_UNDEF; // [RULE7]
      calc_trap = 1'b1;
    end
    else if (spec_reg.op == OP_DIV && b_zero)
    begin
      calc_exc = `EXC_DIVZ; // [RULE8]
      calc_trap = 1'b1;
      calc_res = 64'h0;
    end
    else if (a_zero || b_zero)
      calc_res = (spec_reg.op == OP_MUL || spec_reg.op == OP_DIV || b_zero) ?
        (a_zero || spec_reg.op >= OP_MUL ? (a_zero ? 64'h0 : a_reg) : a_reg) :
        (spec_reg.op == OP_SUB ? {~b_reg[63], b_reg[62:0]} : b_reg);
    else if (ovf)
    begin
      if (ctrl_reg[`CTRL_IV])
      begin
        // Low eight bits of the exponent: 400 octal below the true value.
        calc_exc = `EXC_OVF; // [RULE15] [RULE20]
        calc_trap = 1'b1;
      end
      else
        calc_res = 64'h0; // [RULE21]
    end
    else if (unf)
    begin
      if (ctrl_reg[`CTRL_IU])
      begin
        calc_exc = `EXC_UNF; // [RULE16] [RULE20]
        calc_trap = 1'b1;
      end
      else
        calc_res = 64'h0; // [RULE13]
    end
  end

  // ==========================================================
  // Operand addressing and control
  // ==========================================================
  logic illegal_ac, ac_write;
  logic [15:0] step;
  assign step = double_precision_select ? `STEP_DOUBLE : `STEP_SINGLE; // [RULE3]
  assign illegal_ac = spec_reg.mode == 3'h0 ? spec_reg.ac_sel > 3'h5 : // [RULE4]
    spec_reg.ac_sel > 3'h3; // [RULE5]
  assign start = do_write && wa == `OFF_CTRL && wd_reg[5];
  assign ac_write = state_reg == ST_CALC && !illegal_ac && spec_reg.mode == 3'h0;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    spec_next = spec_reg;
    gpr_next = gpr_reg;
    a_next = a_reg;
    b_next = b_reg;
    res_next = res_reg;
    addr_next = addr_reg;
    step_next = step_reg;
    exc_next = exception_code_reg;
    ovf_next = overflow_flag;
    trap_next = trap_reg;
    state_next = state_reg;
    if (do_write)
    begin
      unique case (wa)
        `OFF_CTRL: ctrl_next = wd_reg[4:0];
        `OFF_OPSPEC: spec_next = wd_reg[10:0];
        `OFF_GPR_IN: gpr_next = wd_reg[15:0];
        // The lowest address word is the most significant one.
        `OFF_A_HI: a_next[63:32] = wd_reg; // [RULE6]
        `OFF_A_LO: a_next[31:0] = wd_reg; // [RULE6]
        `OFF_B_HI: b_next[63:32] = wd_reg;
        `OFF_B_LO: b_next[31:0] = wd_reg;
        default: ;
      endcase
    end
    if (do_write && wa == `OFF_CTRL && wd_reg[6])
      trap_next = 1'b0;
    unique case (state_reg)
      ST_IDLE:
        if (start)
          state_next = ST_CALC;
      ST_CALC:
      begin
        state_next = ST_DONE;
        // Mode 0 reads the accumulator instead of a general register.
        if (spec_reg.mode == 3'h0 && !illegal_ac)
          b_next = float_accumulators[spec_reg.ac_sel]; // [RULE1]
        step_next = step;
        // Effective address follows the host addressing modes.
        unique case (spec_reg.mode) // [RULE2]
          3'h2, 3'h3: addr_next = gpr_reg; // [RULE22]
          3'h4, 3'h5: addr_next = gpr_reg - step; // [RULE3]
          default: addr_next = gpr_reg;
        endcase
        unique case (spec_reg.mode)
          3'h2, 3'h3: gpr_next = gpr_reg + (spec_reg.mode == 3'h2 ? step : 16'h0002); // [RULE3]
          3'h4, 3'h5: gpr_next = gpr_reg - (spec_reg.mode == 3'h4 ? step : 16'h0002);
          default: ;
        endcase
        if (illegal_ac)
        begin
          exc_next = `EXC_ILLOP; // [RULE4] [RULE20]
          trap_next = 1'b1;
        end
        else
        begin
          res_next = calc_res;
          ovf_next = ovf && !(a_zero || b_zero);
          if (calc_trap)
          begin
            exc_next = calc_exc;
            trap_next = 1'b1;
          end
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `CTRL_RESET;
      spec_reg <= '0;
      gpr_reg <= 16'h0000;
      a_reg <= 64'h0;
      b_reg <= 64'h0;
      res_reg <= 64'h0;
      addr_reg <= 16'h0000;
      step_reg <= 16'h0000;
      exception_code_reg <= `EXC_NONE;
      overflow_flag <= 1'b0;
      trap_reg <= 1'b0;
      state_reg <= ST_IDLE;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      spec_reg <= spec_next;
      gpr_reg <= gpr_next;
      a_reg <= a_next;
      b_reg <= b_next;
      res_reg <= res_next;
      addr_reg <= addr_next;
      step_reg <= step_next;
      exception_code_reg <= exc_next;
      overflow_flag <= ovf_next;
      trap_reg <= trap_next;
      state_reg <= state_next;
    end
  end

  // Accumulators are written from the result in mode 0.
  always_ff @(posedge aclk)
  begin
    if (ac_write)
      float_accumulators[spec_reg.ac_sel] <= calc_res; // [RULE1]
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_illegal_ac_trap: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    state_reg == ST_CALC && illegal_ac |=> exception_code_reg == `EXC_ILLOP && trap_reg)
    else $error("illegal accumulator not trapped");
  a_step_size: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    state_reg == ST_CALC && spec_reg.mode == 3'h2 |=> step_reg == (ctrl_reg[1] ? 16'h0008 : 16'h0004))
    else $error("wrong step size");
  a_div_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
    state_reg == ST_CALC && !illegal_ac && spec_reg.op == OP_DIV && b_zero && !neg_zero
    |=> exception_code_reg == `EXC_DIVZ)
    else $error("zero divisor not flagged");
  a_unf_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
    state_reg == ST_CALC && !illegal_ac && !calc_trap && unf && !a_zero && !b_zero
    |=> res_reg == 64'h0)
    else $error("underflow result not zero");
  a_ovf_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE21]
    state_reg == ST_CALC && !illegal_ac && ovf && !ctrl_reg[3] && !a_zero && !b_zero && !neg_zero
    |=> res_reg == 64'h0 && $stable(trap_reg))
    else $error("disabled overflow misbehaved");
  a_ovf_code: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
    state_reg == ST_CALC && !illegal_ac && ovf && ctrl_reg[3] && !a_zero && !b_zero && !neg_zero
    |=> exception_code_reg == `EXC_OVF && res_reg[62:55] == $past(exp_out[7:0]))
    else $error("overflow exponent wrong");
  a_calc_len: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    state_reg == ST_IDLE && start |=> state_reg == ST_CALC ##1 state_reg == ST_DONE)
    else $error("operation sequence wrong");
  a_chop_mode: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE18]
    truncate_select |-> rounded[55:0] == (norm[59:4] & pre_mask))
    else $error("chop mode rounded");

endmodule : fp_operand_address_and_rounding
`default_nettype wire

// ---- fpu_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Bus records shared by the host model and the bench
package fpu_host_pkg;
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axi_m_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_s_t;
endpackage : fpu_host_pkg

// ==========================================================
// Host side of the register bus
module fpu_host_model (
  input wire logic aclk,
  input wire fpu_host_pkg::axi_s_t s,
  output var fpu_host_pkg::axi_m_t m,
  output var logic hang
);
  import fpu_host_pkg::*;

  // Handshakes are judged at the rising edge itself, from the values that stand
  // just before it; every change follows by non-blocking assignment.
  initial
  begin
    m = '0;
    hang = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw;
    logic wv;
    logic b;
    n = 0;
    b = 1'b0;
    resp = 2'b11;
    @(posedge aclk);
    m.awaddr <= {24'h000000, a};
    m.awvalid <= 1'b1;
    m.wdata <= d;
    m.wstrb <= 4'hF;
    m.wvalid <= 1'b1;
    m.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      aw = m.awvalid & s.awready;
      wv = m.wvalid & s.wready;
      b = s.bvalid & m.bready;
      if (b)
        resp = s.bresp;
      if (aw)
        m.awvalid <= 1'b0;
      if (wv)
        m.wvalid <= 1'b0;
      if (b)
        m.bready <= 1'b0;
    end while (!b && n < 40);
    if (!b)
      hang <= 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar;
    logic rv;
    n = 0;
    rv = 1'b0;
    @(posedge aclk);
    m.araddr <= {24'h000000, a};
    m.arvalid <= 1'b1;
    m.rready <= 1'b1;
    d = 32'h0;
    resp = 2'b11;
    do
    begin
      @(posedge aclk);
      n++;
      ar = m.arvalid & s.arready;
      rv = s.rvalid & m.rready;
      if (rv)
      begin
        d = s.rdata;
        resp = s.rresp;
      end
      if (ar)
        m.arvalid <= 1'b0;
      if (rv)
        m.rready <= 1'b0;
    end while (!rv && n < 40);
    if (!rv)
      hang <= 1'b1;
  endtask : rd
endmodule : fpu_host_model

`default_nettype wire

// ---- fp_operand_address_and_rounding_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fpu_regs.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %0t: got %0h want %0h", $time, g, e); end end

module fp_operand_address_and_rounding_tb_top;
  import fpu_host_pkg::*;

  logic aclk;
  logic aresetn;
  logic float_trap;
  logic hang;
  wire axi_m_t m;
  wire axi_s_t s;
  int error_cnt;
  int n_checks;
  int i;
  logic [31:0] d;
  logic [1:0] r;
  int md[6] = '{2, 2, 4, 4, 3, 5};
  int dp[6] = '{0, 2, 0, 2, 0, 0};
  logic [31:0] eg[6] = '{32'h104, 32'h108, 32'hFC, 32'hF8, 32'h102, 32'hFE};
  int im[6] = '{0, 0, 2, 1, 0, 2};
  int ia[6] = '{6, 7, 4, 5, 5, 3};
  logic il[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  fp_operand_address_and_rounding u_fp_operand_address_and_rounding (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(m.awaddr), .s_axi_awvalid(m.awvalid), .s_axi_awready(s.awready),
    .s_axi_wdata(m.wdata), .s_axi_wstrb(m.wstrb), .s_axi_wvalid(m.wvalid),
    .s_axi_wready(s.wready), .s_axi_bresp(s.bresp), .s_axi_bvalid(s.bvalid),
    .s_axi_bready(m.bready), .s_axi_araddr(m.araddr), .s_axi_arvalid(m.arvalid),
    .s_axi_arready(s.arready), .s_axi_rdata(s.rdata), .s_axi_rresp(s.rresp),
    .s_axi_rvalid(s.rvalid), .s_axi_rready(m.rready), .float_trap(float_trap)
  );

  fpu_host_model u_fpu_host_model (.aclk(aclk), .s(s), .m(m), .hang(hang));

  // ==========================================================
  // Clock and closing
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  always @(posedge aclk)
  begin
    if (hang === 1'b1)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ==========================================================
  // Access helpers
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rr;
    u_fpu_host_model.wr(a, v, rr);
  endtask : w

  task automatic c(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rr;
    u_fpu_host_model.rd(a, v, rr);
    `CHK(v, e)
  endtask : c

  function automatic logic [31:0] sp(input int mo, input int rg, input int ac, input int op);
    return {21'h000000, mo[2:0], rg[2:0], ac[2:0], op[1:0]};
  endfunction : sp

  // Clears any trap, loads both operands, starts and waits for the idle state.
  task automatic run(input int ctl, input logic [31:0] spec, input logic [31:0] ahi,
                     input logic [31:0] bhi);
    logic [31:0] st;
    int k;
    w(`OFF_CTRL, ctl | 32'h40);
    w(`OFF_A_HI, ahi);
    w(`OFF_A_LO, 32'h0);
    w(`OFF_B_HI, bhi);
    w(`OFF_B_LO, 32'h0);
    w(`OFF_OPSPEC, spec);
    w(`OFF_CTRL, ctl | 32'h20);
    k = 0;
    st = 32'h3;
    while (st[1:0] !== 2'b00 && k < 20)
    begin
      u_fpu_host_model.rd(`OFF_STATUS, st, r);
      k++;
    end
    if (k >= 20)
    begin
      error_cnt++;
      conclude();
    end
  endtask : run

  // ==========================================================
  // Scenarios
  initial
  begin
    aresetn = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    c(`OFF_CTRL, 32'h0);
    c(`OFF_EXC, 32'h0);
    u_fpu_host_model.rd(8'h40, d, r);
    `CHK(r, 2'b10)
    `CHK(d, 32'h0)
    u_fpu_host_model.wr(8'h40, 32'h1, r);
    `CHK(r, 2'b10)
    run(0, sp(1, 0, 0, 0), 32'h40800000, 32'h40800000);
    c(`OFF_RES_HI, 32'h41000000);
    for (i = 0; i < 2; i++)
    begin
      run(i, sp(1, 0, 0, 0), 32'h40800000, 32'h34800000);
      c(`OFF_RES_HI, (i == 1) ? 32'h40800000 : 32'h40800001);
    end
    run(2, sp(1, 0, 0, 0), 32'h40800000, 32'h34800000);
    c(`OFF_RES_HI, 32'h40800000);
    c(`OFF_RES_LO, 32'h80000000);
    run(0, sp(1, 0, 0, 3), 32'h0, 32'h0);
    c(`OFF_EXC, 32'h4);
    `CHK(float_trap, 1'b1)
    run(4, sp(1, 0, 0, 0), 32'h40800000, 32'h80000000);
    c(`OFF_EXC, 32'hC);
    run(0, sp(1, 0, 0, 0), 32'h40800000, 32'h80000000);
    c(`OFF_RES_HI, 32'h40800000);
    `CHK(float_trap, 1'b0)
    run(8, sp(1, 0, 0, 0), 32'h7FC00000, 32'h7F800000);
    c(`OFF_EXC, 32'h8);
    c(`OFF_RES_HI, 32'h00200000);
    c(`OFF_STATUS, 32'h18);
    run(0, sp(1, 0, 0, 0), 32'h7FC00000, 32'h7F800000);
    c(`OFF_RES_HI, 32'h0);
    `CHK(float_trap, 1'b0)
    run(16, sp(1, 0, 0, 0), 32'h00E00000, 32'h80C00000);
    c(`OFF_EXC, 32'hA);
    c(`OFF_RES_HI, 32'h7F800000);
    run(0, sp(1, 0, 0, 0), 32'h00E00000, 32'h80C00000);
    c(`OFF_RES_HI, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      w(`OFF_GPR_IN, 32'h100);
      run(dp[i], sp(md[i], 1, 0, 0), 32'h40800000, 32'h40800000);
      c(`OFF_GPR_IN, eg[i]);
      if (i < 4)
        c(`OFF_STEP, (dp[i] == 2) ? 32'h8 : 32'h4);
      if (i < 4)
        c(`OFF_ADDR, (md[i] == 2) ? 32'h100 : eg[i]);
    end
    for (i = 0; i < 6; i++)
    begin
      run(0, sp(im[i], 1, ia[i], 0), 32'h40800000, 32'h40800000);
      `CHK(float_trap, il[i])
      if (il[i])
        c(`OFF_EXC, 32'h2);
    end
    conclude();
  end
endmodule : fp_operand_address_and_rounding_tb_top

`default_nettype wire
